// ==== verilog/rhpcb_pkg.sv ====
// constants shared by the root hub port change logic
package rhpcb_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_PORT    = 8'h00;
  localparam logic [7:0] ADR_INT_STS = 8'h04;
  localparam logic [7:0] ADR_INT_CLR = 8'h08;
  localparam logic [7:0] ADR_INT_ENA = 8'h0C;
  localparam logic [7:0] ADR_CFG     = 8'h10;

  // lower word status bits
  localparam int STS_CONNECT  = 0;
  localparam int STS_ENABLED  = 1;
  localparam int STS_SUSPEND  = 2;
  localparam int STS_OVERCUR  = 3;
  localparam int STS_RESET    = 4;

  // lower word write commands
  localparam int WR_CLR_ENABLE  = 0;
  localparam int WR_SET_ENABLE  = 1;
  localparam int WR_SET_SUSPEND = 2;
  localparam int WR_CLR_SUSPEND = 3;
  localparam int WR_SET_RESET   = 4;
  localparam int CMD_W          = 5;

  // upper word change bits
  localparam int CHG_LO         = 16;
  localparam int CHG_CONNECT    = 16;
  localparam int CHG_ENABLE     = 17;
  localparam int CHG_RESUME     = 18;
  localparam int CHG_OVERCUR    = 19;
  localparam int CHG_RESET      = 20;
  localparam int CHG_W          = 5;

  // configuration bits
  localparam int CFG_FIXED      = 0;
  localparam int CFG_PER_PORT   = 1;
  localparam int CFG_HUB_RESET  = 2;

  // reset values
  localparam logic [CHG_W-1:0] CHG_RST  = 5'h00;
  localparam logic [CMD_W-1:0] CMD_RST  = 5'h00;
  localparam logic [1:0]       CFG_RST  = 2'h0;

  // timing
  localparam int CLK_MHZ    = 40;
  localparam int RESET_MS   = 10;
  localparam int RESUME_MS  = 20;
  localparam int RESYNC_MS  = 3;
  localparam int EOP_NS     = 1334;
  localparam int RESET_CYC  = RESET_MS * CLK_MHZ * 1000;
  localparam int RESUME_CYC = RESUME_MS * CLK_MHZ * 1000;
  localparam int RESYNC_CYC = RESYNC_MS * CLK_MHZ * 1000;
  localparam int EOP_CYC    = (EOP_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W      = 20;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET,
    ST_RESUME,
    ST_EOP,
    ST_RESYNC
  } rhpcb_state_t;
endpackage

// ==== verilog/rhpcb_timer.sv ====
// one-shot down counter giving a done pulse after a loaded count
`timescale 1ns/1ps
module rhpcb_timer #(
  parameter int W = 20
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  input  wire logic         abort_i,
  // result
  output logic              done_o
);
  logic [W-1:0] cnt_ff;
  logic         run_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_ff <= count_i;
      run_ff <= 1'b1;
      done_o <= 1'b0;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 1'b1;
      run_ff <= (cnt_ff > 1);
      done_o <= (cnt_ff == 1);
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// ==== verilog/rhpcb_port.sv ====
// root hub port status and change bits behind a classic wishbone slave
// Notes on behaviour
// - reset change set when reset signalling ends
// - change bits clear on write one or hub reset, not on write zero
// - overcurrent change set on indicator change
// - resume change set after pulse, eop, resync
// - resume change cleared when reset change sets
// - enable change only for hardware disables
// - connect change on connect or disconnect
// - enable, suspend and reset commands while disconnected set connect change
// - fixed device: connect change after hub reset
// - status writes wait for transaction end
// - status low word, changes high word
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rhpcb_port
  import rhpcb_pkg::*;
#(
  parameter int RESET_CYCLES  = RESET_CYC,
  parameter int RESUME_CYCLES = RESUME_CYC,
  parameter int EOP_CYCLES    = EOP_CYC,
  parameter int RESYNC_CYCLES = RESYNC_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // port side events
  input  wire logic        dev_connect_i,
  input  wire logic        dev_overcurrent_i,
  input  wire logic        hw_disable_i,
  input  wire logic        xact_busy_i,
  // port signalling
  output logic             port_reset_o,
  output logic             port_resume_o,
  output logic             port_eop_o,
  // interrupt
  output logic             irq_o
);
  rhpcb_state_t      state_ff;
  rhpcb_state_t      nxt_state;
  logic              connect_ff;
  logic              port_enabled_ff;
  logic              suspend_ff;
  logic              port_overcurrent_flag_ff;
  logic [CMD_W-1:0]  pend_ff;
  logic [CMD_W-1:0]  nxt_pend;
  logic              reset_done_change_ff;
  logic              overcurrent_change_ff;
  logic              resume_done_change_ff;
  logic              enable_change_ff;
  logic              connect_change_ff;
  logic [CHG_W-1:0]  int_sts_ff;
  logic [CHG_W-1:0]  int_ena_ff;
  logic [1:0]        cfg_ff;
  logic              hub_rst_ff;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_count;
  logic              tmr_done;

  // bus decode
  logic              acc;
  logic              wr;
  logic              wr_port_lo;
  logic              wr_port_hi;
  logic [CHG_W-1:0]  w1c;
  assign acc        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr         = acc && wb_we_i;
  assign wr_port_lo = wr && wb_adr_i == ADR_PORT && wb_sel_i[0];
  assign wr_port_hi = wr && wb_adr_i == ADR_PORT && wb_sel_i[2];
  assign w1c = wr_port_hi ? wb_dat_i[CHG_RESET:CHG_LO] : '0;

  // command execution and events
  logic x_ok;
  logic do_rst;
  logic do_en;
  logic do_susp;
  logic do_resume;
  logic do_clr_en;
  logic cmd_nc;
  logic ev_connect;
  logic ev_disc;
  logic ev_oc;
  logic ev_hw_dis;
  logic ev_reset_done;
  logic ev_resume_done;
  logic ev_fixed_attach;
  logic [CHG_W-1:0] ev_chg;

  // deferral while a transaction runs
  assign x_ok      = !xact_busy_i;
  assign do_rst    = x_ok && pend_ff[WR_SET_RESET];
  assign do_en     = x_ok && pend_ff[WR_SET_ENABLE];
  assign do_susp   = x_ok && pend_ff[WR_SET_SUSPEND];
  assign do_resume = x_ok && pend_ff[WR_CLR_SUSPEND];
  assign do_clr_en = x_ok && pend_ff[WR_CLR_ENABLE];
  assign cmd_nc    = (do_rst || do_en || do_susp) && !connect_ff;

  // a fixed device never shows attach edges, only the hub reset does
  assign ev_connect = !cfg_ff[CFG_FIXED] && (dev_connect_i != connect_ff);
  assign ev_disc    = ev_connect && connect_ff;
  assign ev_oc      = cfg_ff[CFG_PER_PORT] &&
                      (dev_overcurrent_i != port_overcurrent_flag_ff);
  assign ev_hw_dis  = port_enabled_ff && !hub_rst_ff &&
                      (hw_disable_i || ev_disc ||
                       (ev_oc && dev_overcurrent_i));
  assign ev_reset_done   = state_ff == ST_RESET && tmr_done;
  assign ev_resume_done  = state_ff == ST_RESYNC && tmr_done;
  assign ev_fixed_attach = hub_rst_ff && cfg_ff[CFG_FIXED];

  assign ev_chg = {ev_reset_done, ev_oc, ev_resume_done, ev_hw_dis,
                   ev_connect || cmd_nc || ev_fixed_attach};

  // pending commands, held until the bus transaction ends
  always_comb begin
    nxt_pend = x_ok ? CMD_RST : pend_ff;
    if (wr_port_lo) begin
      nxt_pend = nxt_pend | wb_dat_i[CMD_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hub_rst_ff) begin
      pend_ff <= CMD_RST;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // signalling sequencer
  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_ff)
      ST_IDLE: begin
        if (do_rst && connect_ff) begin
          nxt_state = ST_RESET;
          tmr_load  = 1'b1;
          tmr_count = TMR_W'(RESET_CYCLES);
        end else if (do_resume && suspend_ff) begin
          nxt_state = ST_RESUME;
          tmr_load  = 1'b1;
          tmr_count = TMR_W'(RESUME_CYCLES);
        end
      end
      ST_RESET: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RESUME: begin
        if (tmr_done) begin
          nxt_state = ST_EOP;
          tmr_load  = 1'b1;
          tmr_count = TMR_W'(EOP_CYCLES);
        end
      end
      ST_EOP: begin
        if (tmr_done) begin
          nxt_state = ST_RESYNC;
          tmr_load  = 1'b1;
          tmr_count = TMR_W'(RESYNC_CYCLES);
        end
      end
      ST_RESYNC: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hub_rst_ff) begin
      state_ff      <= ST_IDLE;
      port_reset_o  <= 1'b0;
      port_resume_o <= 1'b0;
      port_eop_o    <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      port_reset_o  <= nxt_state == ST_RESET;
      port_resume_o <= nxt_state == ST_RESUME;
      port_eop_o    <= nxt_state == ST_EOP;
    end
  end

  rhpcb_timer #(
    .W       (TMR_W)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .abort_i (hub_rst_ff),
    .done_o  (tmr_done)
  );

  // port status word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      connect_ff               <= 1'b0;
      port_overcurrent_flag_ff <= 1'b0;
    end else begin
      connect_ff               <= dev_connect_i;
      port_overcurrent_flag_ff <= cfg_ff[CFG_PER_PORT] && dev_overcurrent_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hub_rst_ff) begin
      port_enabled_ff <= 1'b0;
    end else if (ev_hw_dis || do_clr_en) begin
      port_enabled_ff <= 1'b0;
    end else if (ev_reset_done || (do_en && connect_ff)) begin
      port_enabled_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hub_rst_ff) begin
      suspend_ff <= 1'b0;
    end else if (ev_hw_dis || ev_resume_done) begin
      suspend_ff <= 1'b0;
    end else if (do_susp && connect_ff && port_enabled_ff &&
                 state_ff == ST_IDLE) begin
      suspend_ff <= 1'b1;
    end
  end

  // change flags: a set in the same cycle as a write-one clear wins; hub reset clears all but the fixed attach
  always_ff @(posedge clk_i) begin
    if (rst_i || hub_rst_ff) begin
      reset_done_change_ff  <= 1'b0;
      overcurrent_change_ff <= 1'b0;
      resume_done_change_ff <= 1'b0;
      enable_change_ff      <= 1'b0;
      connect_change_ff     <= ev_fixed_attach;
    end else begin
      reset_done_change_ff  <= ev_reset_done ||
        (reset_done_change_ff && !w1c[CHG_RESET-CHG_LO]);
      overcurrent_change_ff <= ev_oc ||
        (overcurrent_change_ff && !w1c[CHG_OVERCUR-CHG_LO]);
      resume_done_change_ff <= !ev_reset_done && (ev_resume_done ||
        (resume_done_change_ff && !w1c[CHG_RESUME-CHG_LO]));
      enable_change_ff      <= ev_hw_dis ||
        (enable_change_ff && !w1c[CHG_ENABLE-CHG_LO]);
      connect_change_ff     <= ev_connect || cmd_nc ||
        (connect_change_ff && !w1c[CHG_CONNECT-CHG_LO]);
    end
  end

  // configuration and hub reset pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff     <= CFG_RST;
      hub_rst_ff <= 1'b1;
    end else begin
      hub_rst_ff <= wr && wb_adr_i == ADR_CFG && wb_sel_i[0] &&
                    wb_dat_i[CFG_HUB_RESET];
      if (wr && wb_adr_i == ADR_CFG && wb_sel_i[0]) begin
        cfg_ff <= wb_dat_i[1:0];
      end
    end
  end

  // interrupt status, clear and enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_sts_ff <= CHG_RST;
      int_ena_ff <= CHG_RST;
      irq_o      <= 1'b0;
    end else begin
      if (wr && wb_adr_i == ADR_INT_CLR && wb_sel_i[0]) begin
        int_sts_ff <= (int_sts_ff & ~wb_dat_i[CHG_W-1:0]) | ev_chg;
      end else begin
        int_sts_ff <= int_sts_ff | ev_chg;
      end
      if (wr && wb_adr_i == ADR_INT_ENA && wb_sel_i[0]) begin
        int_ena_ff <= wb_dat_i[CHG_W-1:0];
      end
      irq_o <= |(int_sts_ff & int_ena_ff);
    end
  end

  // wishbone answer, one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          ADR_PORT: begin
            wb_dat_o <= {11'h000, reset_done_change_ff,
                         overcurrent_change_ff, resume_done_change_ff,
                         enable_change_ff, connect_change_ff, 11'h000,
                         state_ff == ST_RESET, port_overcurrent_flag_ff,
                         suspend_ff, port_enabled_ff,
                         connect_ff};
          end
          ADR_INT_STS: wb_dat_o <= {27'h0000000, int_sts_ff};
          ADR_INT_ENA: wb_dat_o <= {27'h0000000, int_ena_ff};
          ADR_CFG:     wb_dat_o <= {30'h00000000, cfg_ff};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RESET_DONE: assert property (
    (state_ff == ST_RESET && tmr_done && !hub_rst_ff) |=>
      reset_done_change_ff && !port_reset_o)
    else $error("reset change not set at reset end");
  AST_W1C_CLEAR: assert property (
    (w1c[0] && !ev_chg[0] && !hub_rst_ff) |=> !connect_change_ff)
    else $error("connect change not cleared by write one");
  AST_W0_KEEP: assert property (
    (wr_port_hi && !wb_dat_i[CHG_ENABLE] && enable_change_ff &&
     !hub_rst_ff) |=> enable_change_ff)
    else $error("enable change lost on write zero");
  AST_OC_CHANGE: assert property (
    (ev_oc && !hub_rst_ff) |=> overcurrent_change_ff &&
      port_overcurrent_flag_ff == $past(dev_overcurrent_i))
    else $error("overcurrent change missed");
  AST_RESUME_ORDER: assert property (
    $rose(resume_done_change_ff) |-> $past(state_ff) == ST_RESYNC)
    else $error("resume change before full sequence");
  AST_RESUME_CLR: assert property (
    $rose(reset_done_change_ff) |-> !resume_done_change_ff)
    else $error("resume change kept when reset change set");
  AST_ENA_HW_ONLY: assert property (
    $rose(enable_change_ff) |-> $past(ev_hw_dis))
    else $error("enable change without hardware disable");
  AST_CONNECT: assert property (
    (ev_connect && !hub_rst_ff) |=> connect_change_ff)
    else $error("connect change not set on connect event");
  AST_CMD_DISC: assert property (
    (cmd_nc && !hub_rst_ff) |=> connect_change_ff &&
      (state_ff != ST_RESET || $past(state_ff) == ST_RESET))
    else $error("command while disconnected not flagged");
  AST_FIXED: assert property (
    ($past(cfg_ff[CFG_FIXED]) && $rose(connect_change_ff)) |->
      $past(ev_fixed_attach || cmd_nc))
    else $error("fixed device connect change without hub reset");
  AST_DEFER: assert property (
    (xact_busy_i && pend_ff != CMD_RST && !hub_rst_ff) |=>
      (pend_ff & $past(pend_ff)) == $past(pend_ff))
    else $error("status change taken during transaction");
  AST_RSVD: assert property (
    $rose(wb_ack_o) && $past(wb_adr_i) == ADR_PORT && !$past(wb_we_i) |->
      wb_dat_o[31:21] == 11'h000 && wb_dat_o[15:5] == 11'h000)
    else $error("reserved bits not zero");

  COV_RESET_DONE: cover property ($rose(reset_done_change_ff));
  COV_RESUME_DONE: cover property ($rose(resume_done_change_ff));
  COV_HW_DISABLE: cover property ($rose(enable_change_ff));
  COV_DEFER: cover property (xact_busy_i && pend_ff != CMD_RST);
endmodule

// ==== dv/rhpcb_dev_model.sv ====
// behavioural model of the device attached to the root hub port
`timescale 1ns/1ps
module rhpcb_dev_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // scenario control
  input  wire logic       attach_i,
  input  wire logic       oc_i,
  input  wire logic       fault_i,
  input  wire logic       busy_req_i,
  input  wire logic [3:0] busy_len_i,
  // port side
  output logic            dev_connect_o,
  output logic            dev_overcurrent_o,
  output logic            hw_disable_o,
  output logic            xact_busy_o
);
  logic [3:0] busy_cnt_ff;
  logic       fault_ff;
  // line levels settle one cycle after the scenario asks, like a cable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_connect_o     <= 1'b0;
      dev_overcurrent_o <= 1'b0;
    end else begin
      dev_connect_o     <= attach_i;
      dev_overcurrent_o <= oc_i;
    end
  end
  // a fault shows as a single pulse on its rising edge
  always_ff @(posedge clk_i) begin
    fault_ff     <= fault_i & ~rst_i;
    hw_disable_o <= fault_i & ~fault_ff & ~rst_i;
  end
  // transaction length sets a prompt or a slow far side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_cnt_ff <= 4'h0;
    end else if (busy_req_i) begin
      busy_cnt_ff <= busy_len_i;
    end else if (busy_cnt_ff != 4'h0) begin
      busy_cnt_ff <= busy_cnt_ff - 4'h1;
    end
  end
  assign xact_busy_o = (busy_cnt_ff != 4'h0);
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the root hub port change logic
`timescale 1ns/1ps
module tb;
  import rhpcb_pkg::*;
  localparam int RC = 20;
  localparam int SC = 10;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, wb_dat_o, rd, d;
  logic        wb_ack_o, con, oc, dis, busy, irq_o;
  logic        rs_o, rm_o, eop_o;
  logic        attach, oc_req, fault, bq;
  logic [3:0]  blen;
  logic [4:0]  ch;
  int          err_total, n_checks, cycles, seed, len;

  rhpcb_port #(.RESET_CYCLES(RC), .RESUME_CYCLES(30), .EOP_CYCLES(3),
    .RESYNC_CYCLES(SC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dev_connect_i(con), .dev_overcurrent_i(oc), .hw_disable_i(dis),
    .xact_busy_i(busy), .port_reset_o(rs_o), .port_resume_o(rm_o),
    .port_eop_o(eop_o), .irq_o(irq_o));
  rhpcb_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .attach_i(attach),
    .oc_i(oc_req), .fault_i(fault), .busy_req_i(bq), .busy_len_i(blen),
    .dev_connect_o(con), .dev_overcurrent_o(oc), .hw_disable_o(dis),
    .xact_busy_o(busy));

  always #12.5 clk_i = ~clk_i;

  function automatic logic [31:0] pw(input logic [4:0] s, input logic [4:0] c);
    return {11'h000, c, 11'h000, s};
  endfunction
  function automatic logic sig(input int k);
    return (k == 0) ? rs_o : (k == 1) ? rm_o : eop_o;
  endfunction

  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // length of the next high pulse on one signalling output
  task automatic measure(input int k);
    int n;
    n = 0;
    len = 0;
    while (sig(k) !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) err_total++;
    while (sig(k) === 1'b1 && len < 100) begin
      @(posedge clk_i);
      len++;
    end
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    {clk_i, cyc, stb, we, attach, oc_req, fault, bq} = 8'h00;
    {adr, sel, dat, blen} = {8'h00, 4'hF, 32'h0, 4'hC};
    {err_total, n_checks, cycles, seed, rst_i} = {96'h0, 32'd6130, 1'b1};
    idle(16);
    rst_i <= 1'b0;
    idle(2);
    rdc(ADR_PORT, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rdc(8'h14, 32'h0);
    d = $random(seed);
    wr(ADR_INT_ENA, d);
    rdc(ADR_INT_ENA, {27'h0, d[4:0]});
    wr(ADR_INT_ENA, 32'h1);
    attach <= 1'b1;
    idle(4);
    rdc(ADR_PORT, pw(5'h01, 5'h01));
    chk(irq_o, 1);
    wr(ADR_INT_ENA, 32'h0);
    idle(2);
    chk(irq_o, 0);
    wr(ADR_INT_CLR, 32'h1);
    rdc(ADR_INT_STS, 32'h0);
    wr(ADR_PORT, 32'hFFE0FC00);
    rdc(ADR_PORT, pw(5'h01, 5'h01));
    wr(ADR_PORT, 32'h00010000);
    rdc(ADR_PORT, pw(5'h01, 5'h00));
    // start reset during a slow transaction: it has to wait
    bq <= 1'b1;
    @(posedge clk_i);
    bq <= 1'b0;
    wr(ADR_PORT, 32'h10);
    idle(2);
    chk({busy, rs_o}, 2'b10);
    measure(0);
    chk(len >= RC && len <= RC + 2, 1);
    rdc(ADR_PORT, pw(5'h03, 5'h10));
    wr(ADR_PORT, 32'h04);
    rdc(ADR_PORT, pw(5'h07, 5'h10));
    wr(ADR_PORT, 32'h08);
    measure(1);
    chk(len >= 30 && len <= 32, 1);
    measure(2);
    chk(len >= 3 && len <= 5, 1);
    rdc(ADR_PORT, pw(5'h07, 5'h10));
    idle(SC + 4);
    rdc(ADR_PORT, pw(5'h03, 5'h14));
    wr(ADR_PORT, 32'h10);
    measure(0);
    rdc(ADR_PORT, pw(5'h03, 5'h10));
    fault <= 1'b1;
    idle(4);
    fault <= 1'b0;
    rdc(ADR_PORT, pw(5'h01, 5'h12));
    ch = 5'h12;
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      wr(ADR_PORT, d & 32'hFFFFFFE0);
      ch = ch & ~d[20:16];
      rdc(ADR_PORT, pw(5'h01, ch));
    end
    wr(ADR_PORT, 32'h001F0000);
    wr(ADR_PORT, 32'h02);
    wr(ADR_PORT, 32'h01);
    rdc(ADR_PORT, pw(5'h01, 5'h00));
    wr(ADR_CFG, 32'h2);
    wr(ADR_PORT, 32'h02);
    oc_req <= 1'b1;
    idle(4);
    rdc(ADR_PORT, pw(5'h09, 5'h0A));
    oc_req <= 1'b0;
    idle(4);
    rdc(ADR_PORT, pw(5'h01, 5'h0A));
    wr(ADR_PORT, 32'h001F0000);
    attach <= 1'b0;
    idle(4);
    rdc(ADR_PORT, pw(5'h00, 5'h01));
    foreach (ch[k]) if (k != 0 && k != 3) begin
      wr(ADR_PORT, 32'h001F0000);
      wr(ADR_PORT, 32'h1 << k);
      idle(2);
      chk(rs_o, 0);
      rdc(ADR_PORT, pw(5'h00, 5'h01));
    end
    wr(ADR_PORT, 32'h001F0000);
    wr(ADR_CFG, 32'h1);
    attach <= 1'b1;
    idle(4);
    rdc(ADR_PORT, pw(5'h01, 5'h00));
    wr(ADR_CFG, 32'h5);
    idle(2);
    wb(1'b0, ADR_PORT, 32'h0);
    chk(rd & 32'h00010000, 32'h00010000);
    wr(ADR_INT_ENA, 32'h1F);
    idle(2);
    chk(irq_o, 1);
    wr(ADR_INT_CLR, 32'h1F);
    idle(2);
    chk(irq_o, 0);
    end_sim();
  end
endmodule
